// *** osc_switch_pkg.sv ***
/*
 * constants, encodings and register map shared by the oscillator switch
 * and its system-side controller.
 * assumes a single 200 mhz hclk and active-low asynchronous hresetn.
 */
`default_nettype none
package osc_switch_pkg;

    localparam int unsigned CLK_HZ = 200_000_000;

    // source option encoding
    typedef enum logic [1:0] {
        SRC_INTERNAL = 2'b00,
        SRC_EXT_CLOCK = 2'b01,
        SRC_EXT_RC = 2'b10,
        SRC_CRYSTAL = 2'b11
    } source_opt_t;

    // internal frequency codes; 00 is the reset setting
    typedef enum logic [1:0] {
        INT_4M0 = 2'b00,
        INT_8M0 = 2'b01,
        INT_12M8 = 2'b10,
        INT_25M6 = 2'b11
    } int_freq_t;

    // crystal ranges, held in the control register and driven onto the link, where nothing reads them
    typedef enum logic [1:0] {
        XTAL_32K_100K = 2'b00,
        XTAL_1M_8M = 2'b01,
        XTAL_8M_32M = 2'b10
    } xtal_range_t;

    // nominal internal frequencies in khz
    localparam int unsigned INT_KHZ_4M0 = 4000;
    localparam int unsigned INT_KHZ_8M0 = 8000;
    localparam int unsigned INT_KHZ_12M8 = 12800;
    localparam int unsigned INT_KHZ_25M6 = 25600;

    // phase accumulator for the internal oscillator
    localparam int unsigned ACC_W = 24;
    localparam logic [ACC_W-1:0] INC_4M0 = ACC_W'((64'(INT_KHZ_4M0) * 1000 * (64'd1 << ACC_W)) / CLK_HZ);
    localparam logic [ACC_W-1:0] INC_8M0 = ACC_W'((64'(INT_KHZ_8M0) * 1000 * (64'd1 << ACC_W)) / CLK_HZ);
    localparam logic [ACC_W-1:0] INC_12M8 = ACC_W'((64'(INT_KHZ_12M8) * 1000 * (64'd1 << ACC_W)) / CLK_HZ);
    localparam logic [ACC_W-1:0] INC_25M6 = ACC_W'((64'(INT_KHZ_25M6) * 1000 * (64'd1 << ACC_W)) / CLK_HZ);
    localparam int unsigned TRIM_SHIFT = 4;
    localparam int unsigned TRIM_W = 8;

    // activity check before switching
    localparam logic [1:0] EXT_EDGES_NEEDED = 2'd2;

    // controller register map (byte addresses)
    localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
    localparam logic [31:0] TRIM_OFFSET = 32'h0000_0004;
    localparam logic [31:0] STATUS_OFFSET = 32'h0000_0008;

    // control register fields
    localparam int unsigned CTRL_OPT_LSB = 0;
    localparam int unsigned CTRL_RANGE_LSB = 2;
    localparam int unsigned CTRL_FREQ_LSB = 4;
    localparam int unsigned CTRL_GATE_BIT = 6;
    localparam int unsigned CTRL_OUTEN_BIT = 7;
    localparam int unsigned CTRL_KEEP_BIT = 8;
    localparam int unsigned STAT_ACTIVE_BIT = 0;
    localparam int unsigned STAT_STOP_BIT = 1;

    localparam logic [8:0] CTRL_RESET = 9'h000;
    localparam logic [7:0] TRIM_RESET = 8'h00;

endpackage
`default_nettype wire

// *** osc_link_if.sv ***
/*
 * link between the oscillator switch and the system integration logic.
 * assumes both ends run on the same hclk; all signals are levels except
 * the clock ticks, which are one-cycle pulses.
 */
`default_nettype none
interface osc_link_if;
    import osc_switch_pkg::*;

    logic              stop_osc_enable_in;
    logic              keep_osc_in_stop_cfg;
    source_opt_t       source_option_field;
    logic [1:0]        crystal_range_field;
    int_freq_t         internal_freq_field;
    logic [TRIM_W-1:0] internal_trim_value;
    logic              external_gate_request;
    logic              clock_out_pin_enable;
    logic              external_active_status;
    logic              quad_bus_clock;
    logic              double_bus_clock;

    modport dev (
        input  stop_osc_enable_in,
        input  keep_osc_in_stop_cfg,
        input  source_option_field,
        input  crystal_range_field,
        input  internal_freq_field,
        input  internal_trim_value,
        input  external_gate_request,
        input  clock_out_pin_enable,
        output external_active_status,
        output quad_bus_clock,
        output double_bus_clock
    );

    modport ctl (
        output stop_osc_enable_in,
        output keep_osc_in_stop_cfg,
        output source_option_field,
        output crystal_range_field,
        output internal_freq_field,
        output internal_trim_value,
        output external_gate_request,
        output clock_out_pin_enable,
        input  external_active_status,
        input  quad_bus_clock,
        input  double_bus_clock
    );
endinterface
`default_nettype wire

// *** osc_switch_dev.sv ***
/*
 * oscillator source selection and glitch-free switch.
 * internal oscillator is a phase accumulator on hclk; external sources
 * arrive as a level on the clock input pin, synchronous to hclk.
 * clocks leave as one-cycle enable pulses.
 */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
// Contract
// - bus clock is source divided by four
// - internal oscillator has four frequency settings
// - reset selects internal 4 mhz setting
// - bus rates 6.4, 3.2, 2.0, 1.0 mhz
// - crystal offers three frequency ranges; the range field is held and driven onto the link, but nothing reads it
// - stop signal halts oscillators unless overridden; the crystal amplifier output keeps inverting the pin in stop
// - quad clock equals selected source rate
// - double clock is half quad clock
// - signed trim, larger value lowers frequency
// - software copies factory trim value itself
// - internal source drives quad clock on pin
// - software selects crystal first, precharges pin
// - external option enables input pin, crystal output
// - software waits stabilization delay first
// - software sets gate request after delay
// - two external rising edges, then switch
// - set active status, then stop internal
// - option field encodes four sources
// - clearing option and gate returns internal
// - external clock forces pin output off
`default_nettype none
module osc_switch_dev
    import osc_switch_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    osc_link_if.dev          lnk,
    input  wire logic        clock_in_pin_i,
    output logic             clock_in_pin_en,
    output logic             clock_out_pin_o,
    output logic             clock_out_pin_oe
);
    import osc_switch_pkg::*;

    typedef enum logic [1:0] {
        ST_INTERNAL = 2'b00,
        ST_CHECK = 2'b01,
        ST_EXTERNAL = 2'b10,
        ST_RETURN = 2'b11
    } sw_state_t;

    sw_state_t        state_ff,      nxt_state;
    logic [1:0]       edge_cnt_ff,   nxt_edge_cnt;
    logic             int_on_ff,     nxt_int_on;
    logic             use_ext_ff,    nxt_use_ext;
    logic             active_ff,     nxt_active;
    logic             pin_ff,        nxt_pin;
    logic [ACC_W-1:0] acc_ff,        nxt_acc;
    logic             quad_tick_ff,  nxt_quad_tick;
    logic             dbl_phase_ff,  nxt_dbl_phase;
    logic             dbl_tick_ff,   nxt_dbl_tick;
    logic             out_ff,        nxt_out;
    logic             oe_ff,         nxt_oe;
    logic             in_en_ff,      nxt_in_en;

    logic             osc_run;
    logic             ext_selected;
    logic             ext_rise;
    logic             int_wrap;
    logic             src_tick;
    logic             src_level;
    logic [ACC_W-1:0] base_inc;
    logic [ACC_W-1:0] trim_adj;
    logic [ACC_W:0]   acc_sum;

    // control and switch sequencing
    always_comb begin
        osc_run = lnk.stop_osc_enable_in | lnk.keep_osc_in_stop_cfg;
        ext_selected = (lnk.source_option_field != SRC_INTERNAL);
        nxt_pin = clock_in_pin_i;
        ext_rise = ext_selected & osc_run & clock_in_pin_i & ~pin_ff;

        nxt_state = state_ff;
        nxt_edge_cnt = edge_cnt_ff;
        nxt_int_on = int_on_ff;
        nxt_use_ext = use_ext_ff;
        nxt_active = active_ff;
        case (state_ff)
            ST_INTERNAL: begin
                nxt_int_on = 1'b1;
                if (lnk.external_gate_request && ext_selected) begin
                    nxt_state = ST_CHECK;
                    nxt_edge_cnt = 2'd0;
                end
            end
            ST_CHECK: begin
                if (!lnk.external_gate_request || !ext_selected) begin
                    nxt_state = ST_INTERNAL;
                end else if (ext_rise) begin
                    if (edge_cnt_ff == EXT_EDGES_NEEDED - 2'd1) begin
                        // switch on an external edge so no runt pulse appears
                        nxt_use_ext = 1'b1;
                        nxt_active = 1'b1;
                        nxt_state = ST_EXTERNAL;
                    end else begin
                        nxt_edge_cnt = edge_cnt_ff + 2'd1;
                    end
                end
            end
            ST_EXTERNAL: begin
                nxt_int_on = 1'b0;
                if (!lnk.external_gate_request && !ext_selected) begin
                    nxt_int_on = 1'b1;
                    nxt_state = ST_RETURN;
                end
            end
            ST_RETURN: begin
                nxt_use_ext = 1'b0;
                nxt_active = 1'b0;
                nxt_state = ST_INTERNAL;
            end
            default: begin
                nxt_state = ST_INTERNAL;
            end
        endcase
    end

    // internal oscillator and clock outputs
    always_comb begin
        case (lnk.internal_freq_field)
            INT_8M0:  base_inc = INC_8M0;
            INT_12M8: base_inc = INC_12M8;
            INT_25M6: base_inc = INC_25M6;
            default:  base_inc = INC_4M0;
        endcase
        trim_adj = ACC_W'(signed'({{(ACC_W-TRIM_W){lnk.internal_trim_value[TRIM_W-1]}},
                                   lnk.internal_trim_value}) <<< TRIM_SHIFT);
        acc_sum = {1'b0, acc_ff} + {1'b0, base_inc - trim_adj};
        nxt_acc = acc_ff;
        int_wrap = 1'b0;
        if (int_on_ff && osc_run) begin
            nxt_acc = acc_sum[ACC_W-1:0];
            int_wrap = acc_sum[ACC_W];
        end

        src_tick = use_ext_ff ? ext_rise : int_wrap;
        src_level = use_ext_ff ? pin_ff : acc_ff[ACC_W-1];
        nxt_quad_tick = src_tick;
        nxt_dbl_phase = dbl_phase_ff ^ src_tick;
        nxt_dbl_tick = src_tick & dbl_phase_ff;

        nxt_in_en = ext_selected;
        nxt_out = 1'b0;
        nxt_oe = 1'b0;
        case (lnk.source_option_field)
            SRC_CRYSTAL: begin
                nxt_out = ~pin_ff;
                nxt_oe = 1'b1;
            end
            SRC_EXT_CLOCK: begin
                nxt_oe = 1'b0;
            end
            default: begin
                nxt_out = src_level;
                nxt_oe = lnk.clock_out_pin_enable;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_INTERNAL;
            edge_cnt_ff <= 2'd0;
            int_on_ff <= 1'b1;
            use_ext_ff <= 1'b0;
            active_ff <= 1'b0;
            pin_ff <= 1'b0;
            acc_ff <= '0;
            quad_tick_ff <= 1'b0;
            dbl_phase_ff <= 1'b0;
            dbl_tick_ff <= 1'b0;
            out_ff <= 1'b0;
            oe_ff <= 1'b0;
            in_en_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            edge_cnt_ff <= nxt_edge_cnt;
            int_on_ff <= nxt_int_on;
            use_ext_ff <= nxt_use_ext;
            active_ff <= nxt_active;
            pin_ff <= nxt_pin;
            acc_ff <= nxt_acc;
            quad_tick_ff <= nxt_quad_tick;
            dbl_phase_ff <= nxt_dbl_phase;
            dbl_tick_ff <= nxt_dbl_tick;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            in_en_ff <= nxt_in_en;
        end
    end

    assign lnk.external_active_status = active_ff;
    assign lnk.quad_bus_clock = quad_tick_ff;
    assign lnk.double_bus_clock = dbl_tick_ff;
    assign clock_in_pin_en = in_en_ff;
    assign clock_out_pin_o = out_ff;
    assign clock_out_pin_oe = oe_ff;

endmodule
`default_nettype wire

// *** osc_switch_ctl.sv ***
/*
 * system-side controller: ahb-lite slave holding the oscillator controls,
 * stop gating and the final divide by two to the bus clock.
 * assumes one slave on the bus, single word transfers, same hclk.
 */
`default_nettype none
module osc_switch_ctl
    import osc_switch_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    osc_link_if.ctl          lnk,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        stop_mode,
    output logic             bus_clock_tick
);
    import osc_switch_pkg::*;

    logic [8:0]        ctrl_ff,     nxt_ctrl;
    logic [TRIM_W-1:0] trim_ff,     nxt_trim;
    logic              wr_ff,       nxt_wr;
    logic [31:0]       addr_ff,     nxt_addr;
    logic [31:0]       rdata_ff,    nxt_rdata;
    logic              half_ff,     nxt_half;
    logic              bus_tick_ff, nxt_bus_tick;
    logic              stop_ff,     nxt_stop;
    logic              take;

    always_comb begin
        take = hsel & htrans[1] & hready;
        nxt_wr = take & hwrite;
        nxt_addr = take ? haddr : addr_ff;
        nxt_ctrl = ctrl_ff;
        nxt_trim = trim_ff;
        // write lands in the data phase
        if (wr_ff) begin
            if (addr_ff == CTRL_OFFSET) begin
                nxt_ctrl = hwdata[8:0];
            end else if (addr_ff == TRIM_OFFSET) begin
                nxt_trim = hwdata[TRIM_W-1:0];
            end
        end
        // read uses next values so a write just before is seen
        nxt_rdata = rdata_ff;
        if (take && !hwrite) begin
            if (haddr == CTRL_OFFSET) begin
                nxt_rdata = {23'h000000, nxt_ctrl};
            end else if (haddr == TRIM_OFFSET) begin
                nxt_rdata = {24'h000000, nxt_trim};
            end else if (haddr == STATUS_OFFSET) begin
                nxt_rdata = 32'h0000_0000;
                nxt_rdata[STAT_ACTIVE_BIT] = lnk.external_active_status;
                nxt_rdata[STAT_STOP_BIT] = stop_ff;
            end else begin
                nxt_rdata = 32'h0000_0000;
            end
        end
        nxt_stop = stop_mode;
        nxt_half = half_ff ^ lnk.double_bus_clock;
        // bus tick at source over four
        nxt_bus_tick = lnk.double_bus_clock & half_ff;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= CTRL_RESET;
            trim_ff <= TRIM_RESET;
            wr_ff <= 1'b0;
            addr_ff <= 32'h0000_0000;
            rdata_ff <= 32'h0000_0000;
            half_ff <= 1'b0;
            bus_tick_ff <= 1'b0;
            stop_ff <= 1'b0;
        end else begin
            ctrl_ff <= nxt_ctrl;
            trim_ff <= nxt_trim;
            wr_ff <= nxt_wr;
            addr_ff <= nxt_addr;
            rdata_ff <= nxt_rdata;
            half_ff <= nxt_half;
            bus_tick_ff <= nxt_bus_tick;
            stop_ff <= nxt_stop;
        end
    end

    assign hrdata = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign bus_clock_tick = bus_tick_ff;
    assign lnk.stop_osc_enable_in = ~stop_ff;
    assign lnk.keep_osc_in_stop_cfg = ctrl_ff[CTRL_KEEP_BIT];
    assign lnk.source_option_field = source_opt_t'(ctrl_ff[CTRL_OPT_LSB +: 2]);
    assign lnk.crystal_range_field = ctrl_ff[CTRL_RANGE_LSB +: 2];
    assign lnk.internal_freq_field = int_freq_t'(ctrl_ff[CTRL_FREQ_LSB +: 2]);
    // trim only as software wrote it
    assign lnk.internal_trim_value = trim_ff;
    assign lnk.external_gate_request = ctrl_ff[CTRL_GATE_BIT];
    assign lnk.clock_out_pin_enable = ctrl_ff[CTRL_OUTEN_BIT];

endmodule
`default_nettype wire

// *** osc_switch_props.sv ***
/*
 * concurrent checks on the link between the oscillator switch and its
 * controller, plus the clock input pin.
 * assumes one hclk domain, hresetn active low, pin changed on hclk edges.
 */
`default_nettype none
module osc_switch_props (
    input wire logic                        hclk,
    input wire logic                        hresetn,
    input wire logic                        stop_osc_enable_in,
    input wire logic                        keep_osc_in_stop_cfg,
    input wire osc_switch_pkg::source_opt_t source_option_field,
    input wire logic                        external_gate_request,
    input wire logic                        external_active_status,
    input wire logic                        quad_bus_clock,
    input wire logic                        double_bus_clock,
    input wire logic                        clock_in_pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import osc_switch_pkg::*;

    logic       pin_q_ff, nxt_pin_q, rise_w, run_w, armed_w;
    logic [2:0] rise_cnt_ff, nxt_rise_cnt;
    logic [1:0] qo_cnt_ff, nxt_qo_cnt;

    always_comb begin
        rise_w = clock_in_pin_i && !pin_q_ff;
        run_w = stop_osc_enable_in || keep_osc_in_stop_cfg;
        armed_w = external_gate_request && (source_option_field != SRC_INTERNAL);
        nxt_pin_q = clock_in_pin_i;
        nxt_rise_cnt = rise_cnt_ff;
        nxt_qo_cnt = qo_cnt_ff;
        // may count one edge the device misses, so only lower bounds are safe
        if (!armed_w) nxt_rise_cnt = 3'h0;
        else if (run_w && rise_w && rise_cnt_ff != 3'h7) nxt_rise_cnt = rise_cnt_ff + 3'h1;
        if (double_bus_clock) nxt_qo_cnt = 2'h0;
        else if (quad_bus_clock && qo_cnt_ff != 2'h3) nxt_qo_cnt = qo_cnt_ff + 2'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_q_ff <= 1'b0;
            rise_cnt_ff <= 3'h0;
            qo_cnt_ff <= 2'h0;
        end else begin
            pin_q_ff <= nxt_pin_q;
            rise_cnt_ff <= nxt_rise_cnt;
            qo_cnt_ff <= nxt_qo_cnt;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    AST_DBL_WITH_QUAD: assert property (double_bus_clock |-> quad_bus_clock)
        else $error("double clock pulse without quad pulse");
    AST_DBL_EVERY_SECOND: assert property (quad_bus_clock && qo_cnt_ff == 2'h1 |-> double_bus_clock)
        else $error("second quad pulse without double pulse");
    AST_ACT_NEEDS_GATE: assert property ($rose(external_active_status) |->
        external_gate_request && source_option_field != SRC_INTERNAL)
        else $error("active status rose without a switch request");
    AST_ACT_TWO_EDGES: assert property ($rose(external_active_status) |-> rise_cnt_ff >= 3'h2)
        else $error("active status rose before two input edges");
    AST_ACT_BOUNDED: assert property (rise_cnt_ff == 3'h4 && armed_w && run_w |-> ##[0:4]
        external_active_status)
        else $error("switch did not complete after input edges");
    AST_RETURN_CLEARS: assert property (external_active_status && !external_gate_request &&
        source_option_field == SRC_INTERNAL |-> ##[1:3] !external_active_status)
        else $error("active status not cleared on return");
    AST_STOP_HALTS: assert property ((!stop_osc_enable_in && !keep_osc_in_stop_cfg) [*3] |->
        !quad_bus_clock)
        else $error("quad pulse while oscillators stopped");
    AST_EXT_QUAD_FOLLOWS_PIN: assert property (external_active_status && $past(external_active_status, 2)
        && quad_bus_clock |-> $past(rise_w) || $past(rise_w, 2))
        else $error("external quad pulse without input edge");
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
 * bench joining the oscillator switch to its controller over the link.
 * assumes the bench is the only ahb-lite master and makes the external
 * clock on the input pin from hclk edges.
 */
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import osc_switch_pkg::*;

    logic        hclk         = 1'b0;
    logic        hresetn      = 1'b0;
    logic        hsel         = 1'b0;
    logic        hwrite       = 1'b0;
    logic [1:0]  htrans       = 2'h0;
    logic [31:0] haddr        = 32'h0;
    logic [31:0] hwdata       = 32'h0;
    logic        stop_mode    = 1'b0;
    logic        clock_in_pin = 1'b0;
    logic        pin_q        = 1'b0;
    logic        pin_qq       = 1'b0;
    logic        ext_on       = 1'b0;
    logic [31:0] hrdata, v;
    logic        hreadyout, hresp, bus_clock_tick, pin_en, out_o, out_oe;
    int          n_fail = 0, checks_done = 0, seed = 75, cyc = 0, hp = 2, ph = 0;
    int          nq = 0, nd = 0, nt = 0, nr = 0, mq, md, mt, mr, lo;
    int          khz[4] = '{INT_KHZ_4M0, INT_KHZ_8M0, INT_KHZ_12M8, INT_KHZ_25M6};

    osc_link_if lnk_if ();
    osc_switch_dev u_osc_switch_dev (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if.dev),
        .clock_in_pin_i(clock_in_pin), .clock_in_pin_en(pin_en), .clock_out_pin_o(out_o),
        .clock_out_pin_oe(out_oe));
    osc_switch_ctl u_osc_switch_ctl (.hclk(hclk), .hresetn(hresetn), .lnk(lnk_if.ctl), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .stop_mode(stop_mode), .bus_clock_tick(bus_clock_tick));
    osc_switch_props u_osc_switch_props (.hclk(hclk), .hresetn(hresetn),
        .stop_osc_enable_in(lnk_if.stop_osc_enable_in), .keep_osc_in_stop_cfg(lnk_if.keep_osc_in_stop_cfg),
        .source_option_field(lnk_if.source_option_field), .external_gate_request(lnk_if.external_gate_request),
        .external_active_status(lnk_if.external_active_status), .quad_bus_clock(lnk_if.quad_bus_clock),
        .double_bus_clock(lnk_if.double_bus_clock), .clock_in_pin_i(clock_in_pin));

    always #2.5 hclk = ~hclk;

    // external clock stands low while ext_on is clear, as a halted oscillator would
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        nq <= nq + int'(lnk_if.quad_bus_clock === 1'b1);
        nd <= nd + int'(lnk_if.double_bus_clock === 1'b1);
        nt <= nt + int'(bus_clock_tick === 1'b1);
        nr <= nr + int'(clock_in_pin && !pin_q);
        pin_q <= clock_in_pin;
        pin_qq <= pin_q;
        ph <= (ph + 1) % hp;
        if (!ext_on) clock_in_pin <= 1'b0;
        else if (ph == 0) clock_in_pin <= !clock_in_pin;
        if (cyc == 90000) begin
            n_fail = n_fail + 1;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic near(input int got, input int exp, input int tol);
        check(32'(got), (got - exp <= tol && exp - got <= tol) ? 32'(got) : 32'(exp));
    endtask

    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask

    task automatic rdchk(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0, rd);
        check(rd, e);
    endtask

    task automatic meas(input int w);
        int q0, d0, t0, r0;
        q0 = nq;
        d0 = nd;
        t0 = nt;
        r0 = nr;
        repeat (w) @(posedge hclk);
        mq = nq - q0;
        md = nd - d0;
        mt = nt - t0;
        mr = nr - r0;
    endtask

    function automatic int exp_q(input int f, input int w);
        return w * khz[f] / 200000;
    endfunction

    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            if (f != 0) wr(CTRL_OFFSET, 32'(f) << CTRL_FREQ_LSB);
            repeat (60) @(posedge hclk);
            meas(8000);
            near(mq, exp_q(f, 8000), 3);
            near(mt, exp_q(f, 8000) / 4, 2);
            near(md, mq / 2, 1);
        end
        // larger trim must give fewer pulses in the same window
        wr(TRIM_OFFSET, 32'h7f);
        meas(16000);
        lo = mq;
        wr(TRIM_OFFSET, 32'h80);
        meas(16000);
        check(32'(mq > lo), 32'h1);
        rdchk(32'h10, 32'h0);
        repeat (4) begin
            v = $random(seed);
            wr(TRIM_OFFSET, v);
            rdchk(TRIM_OFFSET, v & 32'hff);
            v = v & ~(32'h1 << CTRL_GATE_BIT);
            wr(CTRL_OFFSET, v);
            rdchk(CTRL_OFFSET, v & 32'h1ff);
            wr(32'h10, v);
        end
        hp = 2;
        ext_on <= 1'b1;
        for (int k = 0; k < 8; k++) begin
            wr(CTRL_OFFSET, 32'(k >> 1) | 32'((k & 1) << CTRL_OUTEN_BIT));
            repeat (4) @(posedge hclk);
            @(negedge hclk);
            check(32'(pin_en), 32'(k > 1));
            check(32'(out_oe), 32'((k >> 1) == 3 || ((k >> 1) != 1 && (k & 1) == 1)));
            // pin output is registered from the registered pin sample, two edges behind
            if ((k >> 1) == 3) check(32'(out_o), 32'(!pin_qq));
        end
        wr(CTRL_OFFSET, 32'h1 << CTRL_GATE_BIT);
        repeat (40) @(posedge hclk);
        rdchk(STATUS_OFFSET, 32'h0);
        ext_on <= 1'b0;
        wr(CTRL_OFFSET, 32'h1);
        repeat (20) @(posedge hclk);
        wr(CTRL_OFFSET, 32'h1 | (32'h1 << CTRL_GATE_BIT));
        repeat (60) @(posedge hclk);
        rdchk(STATUS_OFFSET, 32'h0);
        hp = 2 + ($random(seed) & 3);
        ext_on <= 1'b1;
        for (int i = 0; i < 100 && lnk_if.external_active_status !== 1'b1; i++) @(posedge hclk);
        rdchk(STATUS_OFFSET, 32'h1 << STAT_ACTIVE_BIT);
        meas(2000);
        near(mq, mr, 1);
        near(md, mr / 2, 1);
        near(mt, mr / 4, 1);
        wr(CTRL_OFFSET, 32'h0);
        repeat (4) @(posedge hclk);
        rdchk(STATUS_OFFSET, 32'h0);
        ext_on <= 1'b0;
        meas(4000);
        near(mt, exp_q(0, 4000) / 4, 2);
        stop_mode <= 1'b1;
        repeat (10) @(posedge hclk);
        meas(2000);
        check(32'(mq), 32'h0);
        rdchk(STATUS_OFFSET, 32'h1 << STAT_STOP_BIT);
        wr(CTRL_OFFSET, 32'h1 << CTRL_KEEP_BIT);
        repeat (10) @(posedge hclk);
        meas(2000);
        near(mq, exp_q(0, 2000), 3);
        stop_mode <= 1'b0;
        end_sim();
    end
endmodule
`default_nettype wire
